//--- logic/mfr_pkg.sv
// Overview of operation
// - dual output read 3BH: address and dummy byte on one lane, data on two lanes
// - opcode, address, dummy bits sampled on serial clock rise; 3 or 4 address bytes
// - any start address; address advances per output byte while select stays low
// - 24-bit address by default; 32-bit in four-byte mode or four-byte opcode
// - quad output read 6BH: address and dummy byte on one lane, data on four lanes
// - quad output and quad I/O reads need quad_enable set first
// - dual I/O read BBH: address and mode byte two bits per clock, data likewise
// - mode bits 5..4 equal 10: next dual I/O read skips the opcode
// - other mode bits 5..4: next transaction starts with a full opcode
// - reset command clears continuous_read_bits
// - quad I/O read EBH: address, mode byte, four dummy clocks, data on four lanes
// - quad I/O read also has continuous mode when mode bits 5..4 equal 10
// - quad_command_mode: quad I/O dummy count from read_param_dummy_sel, set by C0H
// - quad_command_mode: mode clocks count as dummy; continuous mode still works
// - quad_command_mode: quad I/O never wraps; burst read with wrap 0CH wraps
// - standard mode: set-burst-with-wrap 77H switches wrap for later quad I/O reads
// - wrap: run to aligned section end inside page, jump to section start, repeat
// - wrap_enable_n 0 enables, 1 default; wrap_length_sel picks 8/16/32/64 bytes
// - wrap setting holds for all later standard-mode quad I/O reads until disabled by 77H
// - 0CH in quad_command_mode: fast read with wrap, length and dummy from C0H
`default_nettype none
package mfr_pkg;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_OUT_4B = 8'h3C;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_OUT_4B = 8'h6C;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO_4B = 8'hBC;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_IO_4B = 8'hEC;
	localparam logic [7:0] OP_BURST_WRAP = 8'h0C;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_SET_PARAM = 8'hC0;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [1:0] CONT_MODE_CODE = 2'h2;
	localparam logic [5:0] ADDR_BITS_3B = 6'h18;
	localparam logic [5:0] ADDR_BITS_4B = 6'h20;
	localparam logic [5:0] SPI_DUMMY_CLKS = 6'h08;
	localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
	localparam logic [5:0] DUAL_MODE_CLKS = 6'h04;
	localparam logic [5:0] QUAD_MODE_CLKS = 6'h02;
	localparam logic [5:0] SET_WRAP_BITS = 6'h20;
	localparam logic [5:0] PARAM_BITS = 6'h08;
	localparam logic [5:0] DUMMY_SEL0 = 6'h04;
	localparam logic [5:0] DUMMY_SEL1 = 6'h04;
	localparam logic [5:0] DUMMY_SEL2 = 6'h06;
	localparam logic [5:0] DUMMY_SEL3 = 6'h08;
	localparam logic [7:0] WRAP_MASK_8 = 8'h07;
	localparam logic [7:0] WRAP_MASK_16 = 8'h0F;
	localparam logic [7:0] WRAP_MASK_32 = 8'h1F;
	localparam logic [7:0] WRAP_MASK_64 = 8'h3F;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PARAM = 8'h04;
	localparam logic [7:0] OFF_WRAP = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_ADDR = 8'h10;
	localparam int CTRL_QE_BIT = 0;
	localparam int CTRL_4B_BIT = 1;
	localparam int CTRL_QCM_BIT = 2;
	localparam int PARAM_DUMMY_LSB = 4;
	localparam int PARAM_WRAP_LSB = 0;
	localparam int WRAP_EN_N_BIT = 4;
	localparam int WRAP_LEN_LSB = 5;
	localparam int STAT_CONT_BIT = 8;
	localparam int STAT_BUSY_BIT = 9;
	localparam int STAT_DATA_BIT = 10;
	localparam logic WRAP_EN_N_RESET = 1'b1;

	typedef struct packed {
		logic quad_cmd_mode;
		logic four_byte;
		logic quad_enable;
	} mfr_cfg_s;

	typedef struct packed {
		logic [1:0] dummy_sel;
		logic [1:0] wrap_sel;
	} mfr_param_s;

	typedef struct packed {
		logic [1:0] length_sel;
		logic enable_n;
	} mfr_wrap_s;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_DUAL_OUT = 3'h1,
		CMD_QUAD_OUT = 3'h2,
		CMD_DUAL_IO = 3'h3,
		CMD_QUAD_IO = 3'h4,
		CMD_BURST_WRAP = 3'h5,
		CMD_SET_WRAP = 3'h6,
		CMD_SET_PARAM = 3'h7
	} mfr_cmd_e;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_OPCODE = 7'h02,
		ST_ADDR = 7'h04,
		ST_MODE = 7'h08,
		ST_DUMMY = 7'h10,
		ST_DATA = 7'h20,
		ST_CONFIG = 7'h40
	} mfr_state_e;
endpackage
`default_nettype wire

//--- logic/mfr_read_engine.sv
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
module mfr_read_engine (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output logic pready,
	output var logic pslverr,
	// flash link
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic [3:0] quad_io_lanes_in,
	output var logic [3:0] quad_io_lanes_out,
	output var logic [3:0] quad_io_lanes_oe,
	// array read port
	output var logic [31:0] mem_addr,
	input wire logic [7:0] mem_rdata
);
	logic [2:0] sclk_sync_ff;
	logic [2:0] csn_sync_ff;
	logic [3:0] io_meta_ff;
	logic [3:0] io_sync_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_high;
	mfr_pkg::mfr_cfg_s cfg_ff;
	mfr_pkg::mfr_param_s param_ff;
	mfr_pkg::mfr_wrap_s wrap_ff;
	mfr_pkg::mfr_state_e state_ff;
	mfr_pkg::mfr_cmd_e cmd_ff;
	mfr_pkg::mfr_cmd_e dec_cmd;
	mfr_pkg::mfr_cmd_e sel_cmd;
	logic dec_4b;
	logic dec_reset;
	logic cmd_4b_ff;
	logic sel_4b;
	logic [1:0] wlog_ff;
	logic [5:0] rem_ff;
	logic [31:0] in_sr_ff;
	logic [31:0] nxt_in_sr;
	logic [31:0] addr_ff;
	logic [31:0] nxt_addr;
	logic [31:0] wmask;
	logic [7:0] mode_bits_ff;
	logic cont_ff;
	logic wrap_act_ff;
	logic [1:0] wrap_sel_ff;
	logic [7:0] out_sr_ff;
	logic [2:0] slice_ff;
	logic [1:0] pend_ff;
	logic last_clk;
	logic link_param_wr;
	logic [1:0] a_wlog;
	logic [5:0] a_mode;
	logic [5:0] a_dummy;
	logic [5:0] a_bits;
	logic [1:0] d_wlog;
	logic apb_setup;
	logic apb_wr;
	logic [31:0] nxt_prdata;
	logic nxt_pslverr;

	// sclk and select are asynchronous to pclk: only stage two onward is used
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_sync_ff <= 3'h0;
			csn_sync_ff <= 3'h7;
			io_meta_ff <= 4'h0;
			io_sync_ff <= 4'h0;
		end
		else if (clk_en)
		begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clock};
			csn_sync_ff <= {csn_sync_ff[1:0], chip_select_n};
			io_meta_ff <= quad_io_lanes_in;
			io_sync_ff <= io_meta_ff;
		end
	end

	assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign cs_fall = csn_sync_ff[2] & ~csn_sync_ff[1];
	assign cs_high = csn_sync_ff[1];

	// lanes sampled on sclk rise, msb of each group on the highest lane
	always_comb
	begin
		unique case (wlog_ff)
			2'h1: nxt_in_sr = {in_sr_ff[29:0], io_sync_ff[1:0]};
			2'h2: nxt_in_sr = {in_sr_ff[27:0], io_sync_ff};
			default: nxt_in_sr = {in_sr_ff[30:0], io_sync_ff[0]};
		endcase
	end

	always_comb
	begin
		dec_cmd = mfr_pkg::CMD_NONE;
		dec_4b = 1'b0;
		dec_reset = 1'b0;
		if (cfg_ff.quad_cmd_mode)
		begin
			unique case (nxt_in_sr[7:0])
				mfr_pkg::OP_QUAD_IO, mfr_pkg::OP_QUAD_IO_4B:
				begin
					dec_cmd = cfg_ff.quad_enable ? mfr_pkg::CMD_QUAD_IO : mfr_pkg::CMD_NONE;
					dec_4b = nxt_in_sr[7:0] == mfr_pkg::OP_QUAD_IO_4B;
				end
				mfr_pkg::OP_BURST_WRAP: dec_cmd = mfr_pkg::CMD_BURST_WRAP;
				mfr_pkg::OP_SET_PARAM: dec_cmd = mfr_pkg::CMD_SET_PARAM;
				mfr_pkg::OP_RESET: dec_reset = 1'b1;
				default: dec_cmd = mfr_pkg::CMD_NONE;
			endcase
		end
		else
		begin
			unique case (nxt_in_sr[7:0])
				mfr_pkg::OP_DUAL_OUT, mfr_pkg::OP_DUAL_OUT_4B: dec_cmd = mfr_pkg::CMD_DUAL_OUT;
				mfr_pkg::OP_QUAD_OUT, mfr_pkg::OP_QUAD_OUT_4B:
					dec_cmd = cfg_ff.quad_enable ? mfr_pkg::CMD_QUAD_OUT : mfr_pkg::CMD_NONE;
				mfr_pkg::OP_DUAL_IO, mfr_pkg::OP_DUAL_IO_4B: dec_cmd = mfr_pkg::CMD_DUAL_IO;
				mfr_pkg::OP_QUAD_IO, mfr_pkg::OP_QUAD_IO_4B:
					dec_cmd = cfg_ff.quad_enable ? mfr_pkg::CMD_QUAD_IO : mfr_pkg::CMD_NONE;
				mfr_pkg::OP_SET_WRAP: dec_cmd = mfr_pkg::CMD_SET_WRAP;
				mfr_pkg::OP_RESET: dec_reset = 1'b1;
				default: dec_cmd = mfr_pkg::CMD_NONE;
			endcase
			dec_4b = nxt_in_sr[7:0] == mfr_pkg::OP_DUAL_OUT_4B || nxt_in_sr[7:0] == mfr_pkg::OP_QUAD_OUT_4B
				|| nxt_in_sr[7:0] == mfr_pkg::OP_DUAL_IO_4B || nxt_in_sr[7:0] == mfr_pkg::OP_QUAD_IO_4B;
		end
	end

	assign sel_cmd = (state_ff == mfr_pkg::ST_OPCODE) ? dec_cmd : cmd_ff;
	assign sel_4b = (state_ff == mfr_pkg::ST_OPCODE) ? dec_4b : cmd_4b_ff;
	assign a_bits = (sel_4b || cfg_ff.four_byte) ? mfr_pkg::ADDR_BITS_4B : mfr_pkg::ADDR_BITS_3B;

	// phase shapes per command
	always_comb
	begin
		logic [5:0] dsel;
		dsel = mfr_pkg::DUMMY_SEL0;
		unique case (param_ff.dummy_sel)
			2'h1: dsel = mfr_pkg::DUMMY_SEL1;
			2'h2: dsel = mfr_pkg::DUMMY_SEL2;
			2'h3: dsel = mfr_pkg::DUMMY_SEL3;
			default: dsel = mfr_pkg::DUMMY_SEL0;
		endcase
		a_wlog = 2'h2;
		a_mode = 6'h00;
		a_dummy = 6'h00;
		d_wlog = 2'h2;
		unique case (sel_cmd)
			mfr_pkg::CMD_DUAL_OUT:
			begin
				a_wlog = 2'h0;
				a_dummy = mfr_pkg::SPI_DUMMY_CLKS;
				d_wlog = 2'h1;
			end
			mfr_pkg::CMD_QUAD_OUT:
			begin
				a_wlog = 2'h0;
				a_dummy = mfr_pkg::SPI_DUMMY_CLKS;
			end
			mfr_pkg::CMD_DUAL_IO:
			begin
				a_wlog = 2'h1;
				a_mode = mfr_pkg::DUAL_MODE_CLKS;
				d_wlog = 2'h1;
			end
			mfr_pkg::CMD_QUAD_IO:
			begin
				a_mode = mfr_pkg::QUAD_MODE_CLKS;
				if (!cfg_ff.quad_cmd_mode)
					a_dummy = mfr_pkg::QIO_DUMMY_CLKS;
				else if (dsel > mfr_pkg::QUAD_MODE_CLKS)
					a_dummy = dsel - mfr_pkg::QUAD_MODE_CLKS;
			end
			mfr_pkg::CMD_BURST_WRAP: a_dummy = dsel;
			default: a_wlog = cfg_ff.quad_cmd_mode ? 2'h2 : 2'h0;
		endcase
	end

	// wrap keeps the section base and rolls only the low address bits
	always_comb
	begin
		unique case (wrap_sel_ff)
			2'h0: wmask = {24'h000000, mfr_pkg::WRAP_MASK_8};
			2'h1: wmask = {24'h000000, mfr_pkg::WRAP_MASK_16};
			2'h2: wmask = {24'h000000, mfr_pkg::WRAP_MASK_32};
			default: wmask = {24'h000000, mfr_pkg::WRAP_MASK_64};
		endcase
		if (wrap_act_ff)
			nxt_addr = (addr_ff & ~wmask) | ((addr_ff + 32'h00000001) & wmask);
		else
			nxt_addr = addr_ff + 32'h00000001;
	end

	assign last_clk = sclk_rise && rem_ff == 6'h01;
	assign link_param_wr = last_clk && state_ff == mfr_pkg::ST_CONFIG && cmd_ff == mfr_pkg::CMD_SET_PARAM;

	// link sequencer: phases advance on sampled sclk edges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= mfr_pkg::ST_IDLE;
			cmd_ff <= mfr_pkg::CMD_NONE;
			cmd_4b_ff <= 1'b0;
			wlog_ff <= 2'h0;
			rem_ff <= 6'h00;
			in_sr_ff <= 32'h00000000;
			addr_ff <= 32'h00000000;
			mode_bits_ff <= 8'h00;
			cont_ff <= 1'b0;
			wrap_act_ff <= 1'b0;
			wrap_sel_ff <= 2'h0;
			wrap_ff <= '{length_sel: 2'h0, enable_n: mfr_pkg::WRAP_EN_N_RESET};
			out_sr_ff <= 8'h00;
			slice_ff <= 3'h0;
			pend_ff <= 2'h0;
			quad_io_lanes_out <= 4'h0;
			quad_io_lanes_oe <= 4'h0;
		end
		else if (clk_en)
		begin
			pend_ff <= {pend_ff[0], 1'b0};
			if (pend_ff[1])
				out_sr_ff <= mem_rdata;
			if (cs_high)
			begin
				state_ff <= mfr_pkg::ST_IDLE;
				quad_io_lanes_oe <= 4'h0;
				quad_io_lanes_out <= 4'h0;
			end
			else if (cs_fall)
			begin
				in_sr_ff <= 32'h00000000;
				if (cont_ff)
				begin
					state_ff <= mfr_pkg::ST_ADDR;
					wlog_ff <= a_wlog;
					rem_ff <= a_bits >> a_wlog;
				end
				else
				begin
					state_ff <= mfr_pkg::ST_OPCODE;
					wlog_ff <= cfg_ff.quad_cmd_mode ? 2'h2 : 2'h0;
					rem_ff <= cfg_ff.quad_cmd_mode ? 6'h02 : 6'h08;
				end
			end
			else if (sclk_rise && state_ff != mfr_pkg::ST_IDLE && state_ff != mfr_pkg::ST_DATA)
			begin
				in_sr_ff <= nxt_in_sr;
				rem_ff <= rem_ff - 6'h01;
				if (last_clk)
				begin
					unique case (state_ff)
						mfr_pkg::ST_OPCODE:
						begin
							cmd_ff <= dec_cmd;
							cmd_4b_ff <= dec_4b;
							if (dec_reset)
							begin
								mode_bits_ff <= 8'h00;
								cont_ff <= 1'b0;
							end
							if (dec_cmd == mfr_pkg::CMD_SET_WRAP)
							begin
								state_ff <= mfr_pkg::ST_CONFIG;
								rem_ff <= mfr_pkg::SET_WRAP_BITS;
							end
							else if (dec_cmd == mfr_pkg::CMD_SET_PARAM)
							begin
								state_ff <= mfr_pkg::ST_CONFIG;
								rem_ff <= mfr_pkg::PARAM_BITS >> 2;
							end
							else if (dec_cmd == mfr_pkg::CMD_NONE)
								state_ff <= mfr_pkg::ST_IDLE;
							else
							begin
								state_ff <= mfr_pkg::ST_ADDR;
								wlog_ff <= a_wlog;
								rem_ff <= a_bits >> a_wlog;
							end
						end
						mfr_pkg::ST_ADDR:
						begin
							addr_ff <= a_bits == mfr_pkg::ADDR_BITS_4B ? nxt_in_sr : {8'h00, nxt_in_sr[23:0]};
							pend_ff <= 2'h1;
							// qpi quad i/o never wraps; 0CH always wraps
							wrap_act_ff <= (cmd_ff == mfr_pkg::CMD_QUAD_IO && !cfg_ff.quad_cmd_mode
								&& !wrap_ff.enable_n) || cmd_ff == mfr_pkg::CMD_BURST_WRAP;
							wrap_sel_ff <= cmd_ff == mfr_pkg::CMD_BURST_WRAP ? param_ff.wrap_sel
								: wrap_ff.length_sel;
							if (a_mode != 6'h00)
							begin
								state_ff <= mfr_pkg::ST_MODE;
								rem_ff <= a_mode;
							end
							else
							begin
								state_ff <= mfr_pkg::ST_DUMMY;
								rem_ff <= a_dummy;
							end
						end
						mfr_pkg::ST_MODE:
						begin
							mode_bits_ff <= nxt_in_sr[7:0];
							cont_ff <= nxt_in_sr[5:4] == mfr_pkg::CONT_MODE_CODE;
							if (a_dummy != 6'h00)
							begin
								state_ff <= mfr_pkg::ST_DUMMY;
								rem_ff <= a_dummy;
							end
							else
							begin
								state_ff <= mfr_pkg::ST_DATA;
								wlog_ff <= d_wlog;
								// falls per byte: four on two lanes, two on four lanes
								slice_ff <= d_wlog == 2'h1 ? 3'h4 : 3'h2;
							end
						end
						mfr_pkg::ST_DUMMY:
						begin
							state_ff <= mfr_pkg::ST_DATA;
							wlog_ff <= d_wlog;
							slice_ff <= d_wlog == 2'h1 ? 3'h4 : 3'h2;
						end
						mfr_pkg::ST_CONFIG:
						begin
							state_ff <= mfr_pkg::ST_IDLE;
							if (cmd_ff == mfr_pkg::CMD_SET_WRAP)
								wrap_ff <= nxt_in_sr[6:4];
						end
						default: state_ff <= mfr_pkg::ST_IDLE;
					endcase
				end
			end
			else if (sclk_fall && state_ff == mfr_pkg::ST_DATA)
			begin
				// msb first, lanes move on sclk fall for the host to take on rise
				quad_io_lanes_oe <= wlog_ff == 2'h1 ? 4'h3 : 4'hF;
				quad_io_lanes_out <= wlog_ff == 2'h1 ? {2'h0, out_sr_ff[7:6]} : out_sr_ff[7:4];
				out_sr_ff <= wlog_ff == 2'h1 ? {out_sr_ff[5:0], 2'h0} : {out_sr_ff[3:0], 4'h0};
				if (slice_ff == 3'h1)
				begin
					slice_ff <= wlog_ff == 2'h1 ? 3'h4 : 3'h2;
					addr_ff <= nxt_addr;
					pend_ff <= 2'h1;
				end
				else
					slice_ff <= slice_ff - 3'h1;
			end
		end
	end

	assign mem_addr = addr_ff;

	// apb: zero-wait slave, read data latched in the setup cycle
	assign pready = clk_en;
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;

	always_comb
	begin
		nxt_prdata = 32'h00000000;
		nxt_pslverr = 1'b0;
		unique case (paddr)
			mfr_pkg::OFF_CTRL:
			begin
				nxt_prdata[mfr_pkg::CTRL_QE_BIT] = cfg_ff.quad_enable;
				nxt_prdata[mfr_pkg::CTRL_4B_BIT] = cfg_ff.four_byte;
				nxt_prdata[mfr_pkg::CTRL_QCM_BIT] = cfg_ff.quad_cmd_mode;
			end
			mfr_pkg::OFF_PARAM:
			begin
				nxt_prdata[mfr_pkg::PARAM_DUMMY_LSB +: 2] = param_ff.dummy_sel;
				nxt_prdata[mfr_pkg::PARAM_WRAP_LSB +: 2] = param_ff.wrap_sel;
			end
			mfr_pkg::OFF_WRAP:
			begin
				nxt_prdata[mfr_pkg::WRAP_EN_N_BIT] = wrap_ff.enable_n;
				nxt_prdata[mfr_pkg::WRAP_LEN_LSB +: 2] = wrap_ff.length_sel;
				nxt_pslverr = pwrite;
			end
			mfr_pkg::OFF_STATUS:
			begin
				nxt_prdata[7:0] = mode_bits_ff;
				nxt_prdata[mfr_pkg::STAT_CONT_BIT] = cont_ff;
				nxt_prdata[mfr_pkg::STAT_BUSY_BIT] = state_ff != mfr_pkg::ST_IDLE;
				nxt_prdata[mfr_pkg::STAT_DATA_BIT] = state_ff == mfr_pkg::ST_DATA;
				nxt_pslverr = pwrite;
			end
			mfr_pkg::OFF_ADDR:
			begin
				nxt_prdata = addr_ff;
				nxt_pslverr = pwrite;
			end
			default: nxt_pslverr = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (clk_en && apb_setup)
		begin
			prdata <= pwrite ? 32'h00000000 : nxt_prdata;
			pslverr <= nxt_pslverr;
		end
	end

	// configuration; a C0H on the link wins over a same-cycle apb write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff <= '{quad_cmd_mode: 1'b0, four_byte: 1'b0, quad_enable: 1'b0};
			param_ff <= '{dummy_sel: 2'h0, wrap_sel: 2'h0};
		end
		else if (clk_en)
		begin
			if (apb_wr && paddr == mfr_pkg::OFF_CTRL)
			begin
				cfg_ff.quad_enable <= pwdata[mfr_pkg::CTRL_QE_BIT];
				cfg_ff.four_byte <= pwdata[mfr_pkg::CTRL_4B_BIT];
				cfg_ff.quad_cmd_mode <= pwdata[mfr_pkg::CTRL_QCM_BIT];
			end
			if (link_param_wr)
			begin
				param_ff.dummy_sel <= nxt_in_sr[mfr_pkg::PARAM_DUMMY_LSB +: 2];
				param_ff.wrap_sel <= nxt_in_sr[mfr_pkg::PARAM_WRAP_LSB +: 2];
			end
			else if (apb_wr && paddr == mfr_pkg::OFF_PARAM)
			begin
				param_ff.dummy_sel <= pwdata[mfr_pkg::PARAM_DUMMY_LSB +: 2];
				param_ff.wrap_sel <= pwdata[mfr_pkg::PARAM_WRAP_LSB +: 2];
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/mfr_checker.sv
`default_nettype none
module mfr_checker (
	// clock, reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// link and array
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic [3:0] quad_io_lanes_out,
	input wire logic [3:0] quad_io_lanes_oe,
	input wire logic [31:0] mem_addr
);
	logic sc_ff, qe_ff, act;
	logic [2:0] fall_ff, hi_ff;
	assign act = quad_io_lanes_oe != 4'h0;
	// fall_ff counts pclk cycles since the last link clock fall
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sc_ff <= 1'b0;
			fall_ff <= 3'h7;
			hi_ff <= 3'h0;
			qe_ff <= 1'b0;
		end
		else
		begin
			sc_ff <= serial_clock;
			fall_ff <= (sc_ff && !serial_clock) ? 3'h0 : fall_ff + 3'(fall_ff != 3'h7);
			hi_ff <= !chip_select_n ? 3'h0 : hi_ff + 3'(hi_ff != 3'h7);
			if (psel && penable && pwrite && pready && paddr == mfr_pkg::OFF_CTRL)
				qe_ff <= pwdata[mfr_pkg::CTRL_QE_BIT];
		end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	idle_undriven_a: assert property (hi_ff == 3'h7 |-> !act)
		else $error("lanes driven while deselected");
	deselect_drop_a: assert property ($rose(chip_select_n) |-> ##[1:6] !act)
		else $error("lanes still driven after select rise");
	lane_change_a: assert property (act && $past(act) && $changed(quad_io_lanes_out) |-> fall_ff < 3'h7)
		else $error("lanes changed away from a clock fall");
	drive_start_a: assert property ($rose(act) |-> fall_ff < 3'h7)
		else $error("drive began away from a clock fall");
	quad_needs_qe_a: assert property (!qe_ff |-> quad_io_lanes_oe[3:2] == 2'h0)
		else $error("upper lanes driven without quad enable");
	lane_width_a: assert property (act |-> quad_io_lanes_oe inside {4'h3, 4'hF})
		else $error("odd lane enable pattern");
	addr_step_a: assert property (act && $past(act) && $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 32'h1
		|| mem_addr[31:8] == $past(mem_addr[31:8]) && mem_addr < $past(mem_addr))
		else $error("address step not one byte or in-page wrap");
	wrap_align_a: assert property (act && $past(act) && mem_addr < $past(mem_addr) |-> mem_addr[2:0] == 3'h0)
		else $error("wrap target not section aligned");
	cover property (quad_io_lanes_oe == 4'h3);
	cover property (quad_io_lanes_oe == 4'hF);
	cover property (act && $past(act) && mem_addr < $past(mem_addr));
endmodule
bind mfr_read_engine mfr_checker mfr_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .serial_clock, .chip_select_n, .quad_io_lanes_out, .quad_io_lanes_oe, .mem_addr);
`default_nettype wire

//--- sim/mfr_host_model.sv
`default_nettype none
module mfr_host_model (
	// link
	output var logic serial_clock,
	output var logic chip_select_n,
	output var logic [3:0] drv_val,
	output var logic [3:0] drv_oe,
	input wire logic [3:0] lanes
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] rx;
	initial
	begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		drv_val = 4'h0;
		drv_oe = 4'h0;
		rx = 32'h0;
	end
	// clock stands low outside frames; gap keeps select high well over 3 pclk
	task automatic cs(input logic v);
		#32 chip_select_n = v;
		#200;
	endtask
	// lanes change while clock low so the device samples them on the rise
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [31:0] m;
		m = (32'h1 << w) - 32'h1;
		drv_oe = m[3:0];
		for (int k = n - 1; k >= 0; k--)
		begin
			drv_val = 4'((v >> (k * w)) & m);
			#32 serial_clock = 1'b1;
			#32 serial_clock = 1'b0;
		end
	endtask
	task automatic recv(input int nb, input int w);
		drv_oe = 4'h0;
		rx = 32'h0;
		repeat (nb * 8 / w)
		begin
			#32 serial_clock = 1'b1;
			rx = (rx << w) | 32'(lanes & 4'((1 << w) - 1));
			#32 serial_clock = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- sim/test_multi_io_flash_read_engine.sv
`default_nettype none
`define CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			err_total++; \
			$display("mismatch t=%0t got %h exp %h", $time, a, b); \
		end \
	end
module test_multi_io_flash_read_engine;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, clk_en, psel, penable, pwrite, tg, seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, rd, got;
	logic pready, pslverr, sclk, csn, err;
	logic [3:0] lo, loe, dv, doe, lanes;
	logic [7:0] mem_rdata;
	int err_total = 0, comparisons = 0;
	// released lines show a toggling level, never the last value
	assign lanes = loe & lo | ~loe & (doe & dv | ~doe & {4{tg}});
	assign mem_rdata = mem_addr[7:0] ^ mem_addr[31:24] ^ 8'h3C;
	mfr_read_engine mfr_read_engine_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_clock(sclk), .chip_select_n(csn), .quad_io_lanes_in(lanes),
		.quad_io_lanes_out(lo), .quad_io_lanes_oe(loe), .mem_addr, .mem_rdata);
	mfr_host_model mfr_host_model_i (.serial_clock(sclk), .chip_select_n(csn), .drv_val(dv), .drv_oe(doe), .lanes);
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		tg <= ~tg;
		if ((|loe) === 1'b1)
			seen <= 1'b1;
	end
	function automatic logic [31:0] e3(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		return {8'h00, a[7:0] ^ a[31:24] ^ 8'h3C, b[7:0] ^ b[31:24] ^ 8'h3C, c[7:0] ^ c[31:24] ^ 8'h3C};
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			err_total++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tx(input logic [31:0] v, input int n, input int w);
		mfr_host_model_i.send(v, n, w);
	endtask
	task automatic rxd(input int nb, input int w);
		mfr_host_model_i.recv(nb, w);
		got = mfr_host_model_i.rx;
		mfr_host_model_i.cs(1'b1);
	endtask
	task automatic qio(input logic [31:0] am);
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_QUAD_IO, 8, 1);
		tx(am, 8, 4);
		tx(0, 4, 4);
		rxd(3, 4);
	endtask
	initial
	begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		tg = 1'b0;
		seen = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, mfr_pkg::OFF_WRAP, 0);
		`CHK(rd, 32'h10)
		apb(0, 8'h14, 0);
		`CHK(err, 1'b1)
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_QUAD_OUT, 8, 1);
		tx(32'h10, 32, 1);
		rxd(1, 4);
		`CHK(seen, 1'b0)
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_DUAL_OUT, 8, 1);
		tx(32'hFE00, 32, 1);
		rxd(3, 2);
		`CHK(got, e3(32'hFE, 32'hFF, 32'h100))
		apb(1, mfr_pkg::OFF_CTRL, 32'h3);
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_QUAD_OUT, 8, 1);
		tx(32'h05000020, 32, 1);
		tx(0, 8, 1);
		rxd(3, 4);
		`CHK(got, e3(32'h05000020, 32'h05000021, 32'h05000022))
		apb(1, mfr_pkg::OFF_CTRL, 32'h1);
		// four-byte opcode widens the address without the mode bit
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_DUAL_OUT_4B, 8, 1);
		tx(32'h07000030, 32, 1);
		tx(0, 8, 1);
		rxd(3, 2);
		`CHK(got, e3(32'h07000030, 32'h07000031, 32'h07000032))
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_DUAL_IO, 8, 1);
		tx(32'h4020, 16, 2);
		rxd(3, 2);
		`CHK(got, e3(32'h40, 32'h41, 32'h42))
		mfr_host_model_i.cs(1'b0);
		tx(32'h8000, 16, 2);
		rxd(3, 2);
		`CHK(got, e3(32'h80, 32'h81, 32'h82))
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_DUAL_IO, 8, 1);
		tx(32'hC000, 16, 2);
		rxd(3, 2);
		`CHK(got, e3(32'hC0, 32'hC1, 32'hC2))
		qio(32'h3020);
		`CHK(got, e3(32'h30, 32'h31, 32'h32))
		apb(0, mfr_pkg::OFF_STATUS, 0);
		`CHK(rd[8:0], 9'h120)
		mfr_host_model_i.cs(1'b0);
		tx(32'h50FF, 8, 4);
		tx(0, 4, 4);
		rxd(3, 4);
		`CHK(got, e3(32'h50, 32'h51, 32'h52))
		apb(0, mfr_pkg::OFF_STATUS, 0);
		`CHK(rd[8:0], 9'h0FF)
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_RESET, 8, 1);
		mfr_host_model_i.cs(1'b1);
		apb(0, mfr_pkg::OFF_STATUS, 0);
		`CHK(rd[8:0], 9'h000)
		for (int i = 0; i < 4; i++)
		begin
			mfr_host_model_i.cs(1'b0);
			tx(mfr_pkg::OP_SET_WRAP, 8, 1);
			tx(32'(i) << 5, 32, 1);
			mfr_host_model_i.cs(1'b1);
			apb(0, mfr_pkg::OFF_WRAP, 0);
			`CHK(rd, 32'(i) << 5)
			qio(32'h01FE00);
			`CHK(got, e3(32'h1FE, 32'h1FF, 32'h200 - (32'h8 << i)))
		end
		apb(1, mfr_pkg::OFF_CTRL, 32'h5);
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_SET_PARAM, 2, 4);
		tx(32'h21, 2, 4);
		mfr_host_model_i.cs(1'b1);
		apb(0, mfr_pkg::OFF_PARAM, 0);
		`CHK(rd, 32'h21)
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_BURST_WRAP, 2, 4);
		tx(32'h3E, 6, 4);
		tx(0, 6, 4);
		rxd(3, 4);
		`CHK(got, e3(32'h3E, 32'h3F, 32'h30))
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_QUAD_IO, 2, 4);
		tx(32'h3E00, 8, 4);
		tx(0, 4, 4);
		rxd(3, 4);
		`CHK(got, e3(32'h3E, 32'h3F, 32'h40))
		apb(1, mfr_pkg::OFF_CTRL, 32'h1);
		mfr_host_model_i.cs(1'b0);
		tx(mfr_pkg::OP_SET_WRAP, 8, 1);
		tx(32'h10, 32, 1);
		mfr_host_model_i.cs(1'b1);
		qio(32'h3E00);
		`CHK(got, e3(32'h3E, 32'h3F, 32'h40))
		// frozen enable holds the write off until it returns
		@(posedge pclk);
		clk_en <= 1'b0;
		@(negedge pclk);
		`CHK(pready, 1'b0)
		fork
			apb(1, mfr_pkg::OFF_CTRL, 32'h3);
			begin
				repeat (4) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		apb(0, mfr_pkg::OFF_CTRL, 0);
		`CHK(rd, 32'h3)
		give_verdict();
	end
endmodule
`default_nettype wire
